//--- core/cmp_d_pkg.sv
// Purpose: Shared constants and carriers for the debug comparator D control block
// Assumes: 8-bit register port, 16-bit register address, 24-bit bus address
// Notes:   Field positions and the register offset are named here only once
package cmp_d_pkg;
    localparam int          REG_ADDR_W    = 16;
    localparam int          BUS_ADDR_W    = 24;
    localparam logic [15:0] CTRL_OFFSET   = 16'h0140;
    localparam int          BIT_PC_SEL    = 5;
    localparam int          BIT_DIR_VALUE = 3;
    localparam int          BIT_DIR_QUAL  = 2;
    localparam int          BIT_ON        = 0;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [7:0]  CTRL_WMASK    = 8'h2D;
    localparam logic        DIR_WRITE     = 1'b0;
    localparam logic        DIR_READ      = 1'b1;

    typedef struct packed {
        logic        pc_compare_select;
        logic        direction_value;
        logic        direction_qualify_enable;
        logic        comparator_on;
    } cmp_cfg_s;

    typedef struct packed {
        logic                  valid;
        logic [23:0]           addr;
        logic                  read;
    } data_access_s;

    typedef struct packed {
        logic                  valid;
        logic [23:0]           addr;
    } exec_event_s;
endpackage

//--- core/cmp_d_match.sv
// Purpose: Combinational address and direction match for one comparator
// Assumes: Configuration already resolved between own and pair settings
// Notes:   Pure logic; the top registers the result
`timescale 1ns/1ps
module cmp_d_match (
    input  wire cmp_d_pkg::cmp_cfg_s     cfg,
    input  wire logic [23:0]             cmp_addr,
    input  wire cmp_d_pkg::data_access_s data_acc,
    input  wire cmp_d_pkg::exec_event_s  exec_ev,
    output logic                         hit
);
    import cmp_d_pkg::*;

    logic dir_ok;

    always_comb begin
        // Direction only blocks when qualification is on
        dir_ok = !cfg.direction_qualify_enable
                 || (cfg.direction_value == data_acc.read);
        hit = 1'b0;
        if (cfg.comparator_on) begin
            if (cfg.pc_compare_select) begin
                hit = exec_ev.valid && (exec_ev.addr == cmp_addr);
            end else begin
                hit = data_acc.valid && (data_acc.addr == cmp_addr) && dir_ok;
            end
        end
    end
endmodule

//--- core/debug_address_comparator_d.sv
// Purpose: Control register and match output for debug comparator D
// Assumes: Register port strobes are single cycle and never both high
// Notes:   Writes are dropped while the debug unit is armed
//
// Summary of operation
// - Control at 0x0140, writes only when disarmed
// - Bit 5 selects PC or data compare
// - Bit 3 picks write(0) or read(1) match
// - Bit 2 enables direction qualification, PC ignores
// - Bit 0 enables; disabled never matches
// - Pair range mode uses comparator C control
// - Direction truth table gates data matches
// - PC match at execution, direction independent
`timescale 1ns/1ps
module debug_address_comparator_d (
    input  wire logic                     clock,
    input  wire logic                     resetn,
    input  wire logic [15:0]              reg_addr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_write,
    input  wire logic                     reg_read,
    output logic      [7:0]               reg_rdata,
    input  wire logic                     debug_unit_armed,
    input  wire logic                     comparator_pair_mode,
    input  wire logic [7:0]               comparator_c_control,
    input  wire logic [23:0]              cmp_addr,
    input  wire cmp_d_pkg::data_access_s  data_acc,
    input  wire cmp_d_pkg::exec_event_s   exec_ev,
    output logic                          match
);
    import cmp_d_pkg::*;

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    logic [7:0] comparator_d_control;
    logic       ctrl_sel;

    assign ctrl_sel = (reg_addr == CTRL_OFFSET);

    always_ff @(posedge clock) begin
        if (!resetn) begin
            comparator_d_control <= CTRL_RESET;
        end else if (reg_write && ctrl_sel && !debug_unit_armed) begin
            comparator_d_control <= reg_wdata & CTRL_WMASK;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_read && ctrl_sel) begin
            reg_rdata <= comparator_d_control;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ----------------------------------------
    // Configuration select and match
    // ----------------------------------------
    logic [7:0] eff_ctrl;
    cmp_cfg_s   cfg;
    logic       hit;

    // Range mode hands the whole configuration to comparator C
    assign eff_ctrl = comparator_pair_mode ? comparator_c_control
                                           : comparator_d_control;

    // One writer for the whole carrier keeps the struct single driven
    always_comb begin
        cfg                          = '0;
        cfg.pc_compare_select        = eff_ctrl[BIT_PC_SEL];
        cfg.direction_value          = eff_ctrl[BIT_DIR_VALUE];
        cfg.direction_qualify_enable = eff_ctrl[BIT_DIR_QUAL];
        cfg.comparator_on            = eff_ctrl[BIT_ON];
    end

    cmp_d_match u_match (
        .cfg      (cfg),
        .cmp_addr (cmp_addr),
        .data_acc (data_acc),
        .exec_ev  (exec_ev),
        .hit      (hit)
    );

    always_ff @(posedge clock) begin
        if (!resetn) begin
            match <= 1'b0;
        end else begin
            match <= hit;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_armed_write_blocked: assert property (@(posedge clock) disable iff (!resetn)
        (reg_write && ctrl_sel && debug_unit_armed) |=> $stable(comparator_d_control))
        else $error("control changed while armed");

    chk_write_takes: assert property (@(posedge clock) disable iff (!resetn)
        (reg_write && ctrl_sel && !debug_unit_armed)
        |=> comparator_d_control == ($past(reg_wdata) & CTRL_WMASK))
        else $error("disarmed write not stored");

    chk_read_data: assert property (@(posedge clock) disable iff (!resetn)
        (reg_read && ctrl_sel) |=> reg_rdata == $past(comparator_d_control))
        else $error("read data wrong");

    chk_reserved_zero: assert property (@(posedge clock) disable iff (!resetn)
        (comparator_d_control & ~CTRL_WMASK) == 8'h00)
        else $error("reserved bits set");

    chk_rdata_idle: assert property (@(posedge clock) disable iff (!resetn)
        !(reg_read && ctrl_sel) |=> reg_rdata == 8'h00)
        else $error("read data outside read slot");

    chk_other_addr: assert property (@(posedge clock) disable iff (!resetn)
        (reg_write && !ctrl_sel) |=> $stable(comparator_d_control))
        else $error("unmapped write changed control");

    chk_no_write_hold: assert property (@(posedge clock) disable iff (!resetn)
        !reg_write |=> $stable(comparator_d_control))
        else $error("control changed without write");

    chk_reset_clears: assert property (@(posedge clock)
        !resetn |=> (match == 1'b0 && reg_rdata == 8'h00
                     && comparator_d_control == CTRL_RESET))
        else $error("reset did not clear state");

    // ----------------------------------------
    // Match path checks
    // ----------------------------------------
    // Each check looks one edge after the event, where match is registered
    chk_off_no_match: assert property (@(posedge clock) disable iff (!resetn)
        !eff_ctrl[BIT_ON] |=> !match)
        else $error("match while disabled");

    chk_pc_needs_exec: assert property (@(posedge clock) disable iff (!resetn)
        (eff_ctrl[BIT_PC_SEL] && !exec_ev.valid) |=> !match)
        else $error("pc match without execution");

    chk_pc_hit: assert property (@(posedge clock) disable iff (!resetn)
        (eff_ctrl[BIT_ON] && eff_ctrl[BIT_PC_SEL] && exec_ev.valid
         && exec_ev.addr == cmp_addr) |=> match)
        else $error("pc match missed");

    chk_pc_no_data: assert property (@(posedge clock) disable iff (!resetn)
        (eff_ctrl[BIT_PC_SEL] && data_acc.valid
         && !(exec_ev.valid && exec_ev.addr == cmp_addr)) |=> !match)
        else $error("pc mode matched a data access");

    chk_data_source: assert property (@(posedge clock) disable iff (!resetn)
        (!eff_ctrl[BIT_PC_SEL] && !data_acc.valid) |=> !match)
        else $error("data match without access");

    chk_addr_differs: assert property (@(posedge clock) disable iff (!resetn)
        (!eff_ctrl[BIT_PC_SEL] && data_acc.addr != cmp_addr) |=> !match)
        else $error("data match on other address");

    chk_dir_block: assert property (@(posedge clock) disable iff (!resetn)
        (!eff_ctrl[BIT_PC_SEL] && eff_ctrl[BIT_DIR_QUAL]
         && eff_ctrl[BIT_DIR_VALUE] != data_acc.read) |=> !match)
        else $error("direction mismatch matched");

    chk_read_hit: assert property (@(posedge clock) disable iff (!resetn)
        (eff_ctrl[BIT_ON] && !eff_ctrl[BIT_PC_SEL] && eff_ctrl[BIT_DIR_QUAL]
         && eff_ctrl[BIT_DIR_VALUE] && data_acc.valid && data_acc.read
         && data_acc.addr == cmp_addr) |=> match)
        else $error("qualified read missed");

    chk_write_hit: assert property (@(posedge clock) disable iff (!resetn)
        (eff_ctrl[BIT_ON] && !eff_ctrl[BIT_PC_SEL] && eff_ctrl[BIT_DIR_QUAL]
         && !eff_ctrl[BIT_DIR_VALUE] && data_acc.valid && !data_acc.read
         && data_acc.addr == cmp_addr) |=> match)
        else $error("qualified write missed");

    chk_dir_free: assert property (@(posedge clock) disable iff (!resetn)
        (eff_ctrl[BIT_ON] && !eff_ctrl[BIT_PC_SEL] && !eff_ctrl[BIT_DIR_QUAL]
         && data_acc.valid && data_acc.addr == cmp_addr) |=> match)
        else $error("unqualified access missed");

    chk_pair_mode: assert property (@(posedge clock) disable iff (!resetn)
        (comparator_pair_mode && !comparator_c_control[BIT_ON]) |=> !match)
        else $error("own control used in range mode");

    chk_pair_governs: assert property (@(posedge clock) disable iff (!resetn)
        (comparator_pair_mode && comparator_c_control[BIT_ON]
         && !comparator_c_control[BIT_PC_SEL] && !comparator_c_control[BIT_DIR_QUAL]
         && data_acc.valid && data_acc.addr == cmp_addr) |=> match)
        else $error("pair control not applied");

    // ----------------------------------------
    // Coverage of the main scenarios
    // ----------------------------------------
    cov_pc_match:   cover property (@(posedge clock) eff_ctrl[BIT_PC_SEL] ##1 match);
    cov_read_match: cover property (@(posedge clock)
        eff_ctrl[BIT_DIR_QUAL] && data_acc.read ##1 match);
    cov_armed_wr:   cover property (@(posedge clock)
        reg_write && ctrl_sel && debug_unit_armed);
    cov_range:      cover property (@(posedge clock) comparator_pair_mode ##1 match);
    cov_write_match: cover property (@(posedge clock)
        eff_ctrl[BIT_DIR_QUAL] && !data_acc.read ##1 match);
endmodule

//--- test/cmp_d_bus_model.sv
// Purpose: Core side model that issues data accesses and execution events
// Assumes: Called once per clock, right after the rising edge
// Notes:   Idle address lines show a pattern that changes every cycle
`timescale 1ns/1ps
module cmp_d_bus_model
    import cmp_d_pkg::*;
(
    output cmp_d_pkg::data_access_s data_acc,
    output cmp_d_pkg::exec_event_s  exec_ev
);
    logic [23:0] last_addr = 24'h000000;
    initial begin
        data_acc = '0;
        exec_ev  = '0;
    end
    task automatic issue(input logic dv, input logic ev, input logic [23:0] ba, input logic rd);
        logic [23:0] shown;
        shown     = (dv || ev) ? ba : ~last_addr;
        last_addr = shown;
        data_acc <= {dv, shown, dv ? rd : shown[0]};
        exec_ev  <= {ev, shown};
    endtask
endmodule

//--- test/debug_address_comparator_d_tb_top.sv
// Purpose: Self-checking bench for the comparator D control block
// Assumes: Expected outputs come from a shadow of the control register
// Notes:   Each note pushed at one edge is compared just after that same edge
`timescale 1ns/1ps
module debug_address_comparator_d_tb_top;
    import cmp_d_pkg::*;
    logic clock = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0, match;
    logic debug_unit_armed = 1'b0, comparator_pair_mode = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0]  reg_wdata = 8'h00, comparator_c_control = 8'h00, reg_rdata, ctrl = 8'h00;
    logic [23:0] cmp_addr = 24'h000000, want_cmp = 24'h00ABCD;
    logic [7:0]  want_c = 8'h00;
    logic        want_armed = 1'b0, want_pair = 1'b0;
    logic [8:0]  pend = 9'h000, note;
    logic [8:0]  note_q[$];
    logic [31:0] rnd;
    data_access_s data_acc;
    exec_event_s  exec_ev;
    int errors = 0, checked = 0, seed = 32'h023a;
    always #2 clock = ~clock;
    cmp_d_bus_model bus_model_pc_compare_select (.data_acc(data_acc), .exec_ev(exec_ev));
    debug_address_comparator_d debug_address_comparator_d_pc_compare_select (.clock(clock), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .debug_unit_armed(debug_unit_armed),
        .comparator_pair_mode(comparator_pair_mode), .comparator_c_control(comparator_c_control),
        .cmp_addr(cmp_addr), .data_acc(data_acc), .exec_ev(exec_ev), .match(match));
    // ------------------------------------------------
    // Driver: one call per cycle, notes expected outputs
    // ------------------------------------------------
    task automatic step(input logic w, input logic r, input logic [15:0] a, input logic [7:0] wd,
                        input logic dv, input logic ev, input logic [23:0] ba, input logic rd);
        logic [7:0] cfg;
        logic       hit;
        @(posedge clock);
        note_q.push_back(pend);
        reg_write <= w;
        reg_read <= r;
        reg_addr <= a;
        reg_wdata <= wd;
        debug_unit_armed <= want_armed;
        comparator_pair_mode <= want_pair;
        comparator_c_control <= want_c;
        cmp_addr <= want_cmp;
        bus_model_pc_compare_select.issue(dv, ev, ba, rd);
        cfg = want_pair ? want_c : ctrl;
        hit = cfg[BIT_ON] && (cfg[BIT_PC_SEL] ? (ev && ba == want_cmp)
            : (dv && ba == want_cmp && (!cfg[BIT_DIR_QUAL] || rd == cfg[BIT_DIR_VALUE])));
        pend = {(r && a == CTRL_OFFSET) ? ctrl : 8'h00, hit};
        if (w && a == CTRL_OFFSET && !want_armed) ctrl = wd & CTRL_WMASK;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    always @(posedge clock) begin
        #1;
        while (note_q.size() > 0) begin
            note = note_q.pop_front();
            check(reg_rdata, note[8:1]);
            check({7'h00, match}, {7'h00, note[0]});
        end
    end
    task automatic summarize;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ------------------------------------------------
    // Tests
    // ------------------------------------------------
    initial begin
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        step(0, 1, CTRL_OFFSET, 8'h00, 0, 0, 24'h0, 0);
        step(1, 0, CTRL_OFFSET, 8'hFF, 0, 0, 24'h0, 0);
        step(0, 1, CTRL_OFFSET, 8'h00, 0, 0, 24'h0, 0);
        want_armed = 1'b1;
        step(1, 0, CTRL_OFFSET, 8'h00, 0, 0, 24'h0, 0);
        want_armed = 1'b0;
        step(0, 1, CTRL_OFFSET, 8'h00, 0, 0, 24'h0, 0);
        step(1, 0, 16'h0141, 8'h00, 0, 0, 24'h0, 0);
        step(0, 1, 16'h0141, 8'h00, 0, 0, 24'h0, 0);
        step(0, 1, CTRL_OFFSET, 8'h00, 0, 0, 24'h0, 0);
        $display("test register access done");
        for (int i = 0; i < 32; i++) begin
            rnd = i;
            step(1, 0, CTRL_OFFSET, {2'b00, rnd[4], 1'b0, rnd[3:2], 2'b01}, 0, 0, 24'h0, 0);
            step(0, 0, 16'h0000, 8'h00, !rnd[0], rnd[0], want_cmp, rnd[1]);
        end
        $display("test direction table done");
        for (int i = 0; i < 3000; i++) begin
            rnd = $random(seed);
            want_armed = rnd[0];
            want_pair = rnd[1] & rnd[2];
            want_c = rnd[19:12];
            if (rnd[11] & rnd[12]) want_cmp = rnd[31:8];
            step(rnd[4] & ~rnd[5], rnd[5] & ~rnd[4], rnd[6] ? CTRL_OFFSET : rnd[31:16],
                 rnd[15:8], rnd[7], rnd[8], rnd[9] ? want_cmp : rnd[31:8], rnd[10]);
        end
        step(0, 0, 16'h0000, 8'h00, 0, 0, 24'h0, 0);
        step(0, 0, 16'h0000, 8'h00, 0, 0, 24'h0, 0);
        repeat (2) @(posedge clock);
        $display("test random traffic done");
        summarize();
    end
    initial begin
        #200000;
        errors++;
        summarize();
    end
endmodule
